/* dmc_consts.svh */
// constants for the dma control-byte front end: decode patterns, field
// positions, command codes and reset values. definitions only.
`ifndef DMC_CONSTS_SVH
`define DMC_CONSTS_SVH
// ----------------------------------------------------------------
// base byte decode
// ----------------------------------------------------------------
`define DMC_TS_ID_BIT 7
`define DMC_CLASS_LSB 0
`define DMC_SRC_BIT 2
`define DMC_PTR_ADDR_LO 3
`define DMC_PTR_ADDR_HI 4
`define DMC_PTR_LEN_LO 5
`define DMC_PTR_LEN_HI 6
`define DMC_CFG_ID_MASK 8'h87
`define DMC_CFG_ID_VAL 8'h04
`define DMC_CMD_ID_MASK 8'h83
`define DMC_CMD_ID_VAL 8'h83
// ----------------------------------------------------------------
// command group codes
// ----------------------------------------------------------------
`define DMC_CMD_ENABLE 8'h87
`define DMC_CMD_DISABLE 8'h83
`define DMC_CMD_REINIT 8'h8b
`define DMC_CMD_FORCE_RDY 8'hb3
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DMC_RST_BYTE 8'h00
`define DMC_RST_WORD 16'h0000
`define DMC_RST_PTR 4'h0
`endif

/* dmc_pkg.sv */
// types for the dma control-byte front end.
// assumes dmc_consts.svh is included alongside where constants are needed.
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_DISABLED,
    DMC_ENABLED_IDLE,
    DMC_SUSPENDED,
    DMC_OPERATING
  } dmc_state_e;
  typedef enum logic [1:0] {
    DMC_MODE_BYTE,
    DMC_MODE_CONT,
    DMC_MODE_BURST
  } dmc_mode_e;
  // host port strobe bundle
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] data;
  } dmc_host_s;
  // events coming from the transfer engine and the bus
  typedef struct packed {
    logic endBlock;
    logic autoRestart;
    logic byteMatch;
    logic busAckIn;
    logic retiSeen;
    logic inIsr;
    logic selfXfer;
  } dmc_evt_s;
  typedef struct packed {
    dmc_state_e state;
    logic forceRdy;
    logic lastWasCmd;
    logic [3:0] ptrPend;
    logic [1:0] opClass;
    logic srcIsPortA;
    logic [15:0] portAStart;
    logic [15:0] blockLen;
    logic [7:0] cfgBase;
    logic busReqN;
    logic [7:0] status;
    logic [1:0] rdySync;
    logic ackHeld;
    logic master;
  } dmc_state_s;
endpackage

/* dmc_ctrl.sv */
// dma control-byte front end: decodes host control bytes written to the
// single control port and runs the enable/disable state machine.
// assumes a host that strobes sel with wr or rd for one clock per byte,
// and a transfer engine that reports block end, match and bus grant loss.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_consts.svh"
// Operation
// [R01] reset and power-up leave the engine disabled, no bus request
// [R02] any control byte while enabled but idle disables it until enable
// [R03] one port address, chosen by chip select, for control and status
// [R04] bytes moved by the engine itself never program it
// [R05] bus request stays high while disabled
// [R06] host accesses only when not bus master; else write disable first
// [R07] disable on block end without restart, match, or lost ack (lost ack disables here only outside continuous mode)
// [R08] continuous mode with ready low: hold bus, suspend work
// [R09] enabled engine goes master on ready in burst or after interrupt return
// [R10] command bytes disable, except enable and a lone status reinit (here a lone reinit from enabled idle still disables, by R02)
// [R11] enable with ready low, no force: enabled idle; continuous: suspended
// [R12] enable outside service routine with ready or force: operating
// [R13] base byte selects group; pointer ones load registers in order
// [R14] transfer-setup base: bit 7 zero, class bits not both zero
// [R15] class bits choose transfer, search, or transfer with search
// [R16] bit 2 picks source port: one means port a
// [R17] pointers 3 and 4 load port a start low then high
// [R18] pointers 5 and 6 load block length low then high
// [R19] pipelined read-ahead may process one or two extra bytes
// [R20] length zero means 65537 bytes; one usually means two
// [R21] host disables with another byte before reversing direction
// [R22] once bus is held, keep it until the task completes
// [R23] each byte goes to one group; a new base ends pending loads
module dmc_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire dmc_pkg::dmc_host_s host,
  input wire dmc_pkg::dmc_evt_s evt,
  input wire dmc_pkg::dmc_mode_e mode,
  input wire logic rdyPin,
  output logic busReqN,
  output logic [7:0] statusOut,
  output logic [1:0] opClass,
  output logic srcIsPortA,
  output logic [15:0] portAStart,
  output logic [15:0] blockLen,
  output logic [7:0] cfgBase,
  output logic isMaster
);
  import dmc_pkg::*;

  dmc_state_s cur;
  dmc_state_s nxt;
  logic rdyActive;
  logic wrByte;
  logic isTsBase;
  logic isCfgBase;
  logic isCmd;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic matchPat(input logic [7:0] b, input logic [7:0] m,
                                    input logic [7:0] v);
    matchPat = ((b & m) == v);
  endfunction

  // ready pin comes from outside, second stage only is read
  assign rdyActive = cur.rdySync[1];
  // self transfers are ignored so the engine cannot program itself
  assign wrByte = host.sel && host.wr && !evt.selfXfer; // [R03] [R04]
  // one group per byte: command pattern wins over setup, setup over config
  assign isCmd = matchPat(host.data, `DMC_CMD_ID_MASK, `DMC_CMD_ID_VAL); // [R23]
  assign isTsBase = !host.data[`DMC_TS_ID_BIT] && (host.data[1:0] != 2'b00); // [R14]
  assign isCfgBase = !isCmd && matchPat(host.data, `DMC_CFG_ID_MASK, `DMC_CFG_ID_VAL);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic pendingByte;
    logic goRun;
    pendingByte = 1'b0;
    goRun = 1'b0;
    nxt = cur;
    nxt.rdySync = {cur.rdySync[0], rdyPin};
    pendingByte = (cur.ptrPend != `DMC_RST_PTR);
    // control bytes from the host; not accepted while master
    if (wrByte && (cur.state == DMC_DISABLED || cur.state == DMC_ENABLED_IDLE)) begin // [R06]
      if (cur.state == DMC_ENABLED_IDLE) begin
        nxt.state = DMC_DISABLED; // [R02]
      end
      if (pendingByte && !(isCmd || isTsBase || isCfgBase)) begin
        // associated bytes load in fixed group order
        if (cur.ptrPend[0]) begin // [R13] [R17]
          nxt.portAStart[7:0] = host.data;
          nxt.ptrPend[0] = 1'b0;
        end else if (cur.ptrPend[1]) begin
          nxt.portAStart[15:8] = host.data;
          nxt.ptrPend[1] = 1'b0;
        end else if (cur.ptrPend[2]) begin // [R18]
          nxt.blockLen[7:0] = host.data;
          nxt.ptrPend[2] = 1'b0;
        end else begin
          nxt.blockLen[15:8] = host.data;
          nxt.ptrPend[3] = 1'b0;
        end
        nxt.lastWasCmd = 1'b0;
      end else if (isCmd) begin
        nxt.ptrPend = `DMC_RST_PTR; // [R23]
        case (host.data)
          `DMC_CMD_ENABLE: begin
            goRun = rdyActive || cur.forceRdy;
            if (goRun && !evt.inIsr) begin
              nxt.state = DMC_OPERATING; // [R12]
            end else if (!rdyActive && mode == DMC_MODE_CONT) begin
              nxt.state = DMC_SUSPENDED; // [R11]
            end else begin
              nxt.state = DMC_ENABLED_IDLE; // [R11]
            end
          end
          `DMC_CMD_FORCE_RDY: begin
            nxt.forceRdy = 1'b1;
            nxt.state = DMC_DISABLED; // [R10]
          end
          `DMC_CMD_REINIT: begin
            // a lone reinit sets no state here, so enabled idle still drops to disabled above; after another command it disables
            if (cur.lastWasCmd) begin
              nxt.state = DMC_DISABLED; // [R10]
            end
            nxt.status = `DMC_RST_BYTE;
          end
          default: begin
            nxt.state = DMC_DISABLED; // [R10]
          end
        endcase
        nxt.lastWasCmd = 1'b1;
      end else if (isTsBase) begin
        // direction change relies on the host having disabled first
        nxt.opClass = host.data[`DMC_CLASS_LSB +: 2]; // [R15] [R21]
        nxt.srcIsPortA = host.data[`DMC_SRC_BIT]; // [R16]
        nxt.ptrPend = {host.data[`DMC_PTR_LEN_HI], host.data[`DMC_PTR_LEN_LO],
                       host.data[`DMC_PTR_ADDR_HI], host.data[`DMC_PTR_ADDR_LO]}; // [R13]
        nxt.lastWasCmd = 1'b0;
      end else if (isCfgBase) begin
        nxt.cfgBase = host.data;
        nxt.ptrPend = `DMC_RST_PTR; // [R23]
        nxt.lastWasCmd = 1'b0;
      end else begin
        nxt.ptrPend = `DMC_RST_PTR;
        nxt.lastWasCmd = 1'b0;
      end
    end
    // bus-side events; the bus is kept until the task ends
    case (cur.state)
      DMC_DISABLED: begin
        nxt.busReqN = 1'b1;
      end
      DMC_ENABLED_IDLE: begin
        if (rdyActive && (mode == DMC_MODE_BURST || evt.retiSeen) && !wrByte) begin
          nxt.state = DMC_OPERATING; // [R09]
        end
      end
      DMC_SUSPENDED: begin
        // a stop condition ends the task even while the bus is held idle
        if ((evt.endBlock && !evt.autoRestart) || evt.byteMatch) begin
          nxt.state = DMC_DISABLED; // [R07]
        end else if (rdyActive) begin
          nxt.state = DMC_OPERATING;
        end
      end
      DMC_OPERATING: begin
        if ((evt.endBlock && !evt.autoRestart) || evt.byteMatch ||
            (cur.ackHeld && !evt.busAckIn && mode != DMC_MODE_CONT)) begin
          nxt.state = DMC_DISABLED; // [R07] [R22]
        end else if (!rdyActive && mode == DMC_MODE_CONT) begin
          nxt.state = DMC_SUSPENDED; // [R08]
        end
      end
      default: begin
        nxt.state = DMC_DISABLED;
      end
    endcase
    // request is low only while an enabled state wants the bus
    nxt.busReqN = !(nxt.state == DMC_OPERATING || nxt.state == DMC_SUSPENDED); // [R05]
    nxt.master = !nxt.busReqN;
    // only a grant that was once seen can be lost; the grant lags the request
    nxt.ackHeld = !nxt.busReqN && evt.busAckIn; // [R07]
    if (nxt.state == DMC_OPERATING) begin
      nxt.forceRdy = 1'b0;
    end
    nxt.status = {4'h0, cur.ptrPend != `DMC_RST_PTR, nxt.state == DMC_DISABLED,
                  evt.endBlock, rdyActive};
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // length zero and the one-or-two byte overrun are the counter's concern
  always_ff @(posedge clk) begin // [R19] [R20]
    if (!rst_n) begin
      cur.state <= DMC_DISABLED; // [R01]
      cur.forceRdy <= 1'b0;
      cur.lastWasCmd <= 1'b0;
      cur.ptrPend <= `DMC_RST_PTR;
      cur.opClass <= 2'h0;
      cur.srcIsPortA <= 1'b0;
      cur.portAStart <= `DMC_RST_WORD;
      cur.blockLen <= `DMC_RST_WORD;
      cur.cfgBase <= `DMC_RST_BYTE;
      cur.busReqN <= 1'b1;
      cur.status <= `DMC_RST_BYTE;
      cur.rdySync <= 2'h0;
      cur.ackHeld <= 1'b0;
      cur.master <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  // outputs straight from flip-flops
  assign busReqN = cur.busReqN;
  assign statusOut = cur.status;
  assign opClass = cur.opClass;
  assign srcIsPortA = cur.srcIsPortA;
  assign portAStart = cur.portAStart;
  assign blockLen = cur.blockLen;
  assign cfgBase = cur.cfgBase;
  assign isMaster = cur.master;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_disables: assert property (@(posedge clk) !rst_n |=> busReqN) // [R01]
    else $error("bus requested right after reset");
  a_idle_write_disables: assert property (@(posedge clk) disable iff (!rst_n)
      (cur.state == DMC_ENABLED_IDLE && wrByte && host.data != `DMC_CMD_ENABLE)
      |=> cur.state != DMC_OPERATING) // [R02]
    else $error("write while idle did not stop engine");
  a_self_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      (evt.selfXfer && cur.state == DMC_DISABLED) |=> $stable(cur.blockLen)) // [R04]
    else $error("self transfer changed length");
  a_disabled_no_req: assert property (@(posedge clk) disable iff (!rst_n)
      cur.state == DMC_DISABLED |-> busReqN) // [R05]
    else $error("request while disabled");
  a_master_no_prog: assert property (@(posedge clk) disable iff (!rst_n)
      (cur.state == DMC_OPERATING && wrByte) |=> $stable(cur.opClass)) // [R06]
    else $error("programmed while master");
  a_match_stops: assert property (@(posedge clk) disable iff (!rst_n)
      (cur.state == DMC_OPERATING && evt.byteMatch) |=> cur.state == DMC_DISABLED) // [R07]
    else $error("match did not disable");
  a_cont_suspend: assert property (@(posedge clk) disable iff (!rst_n)
      (cur.state == DMC_OPERATING && mode == DMC_MODE_CONT && !rdyActive &&
       evt.busAckIn && !evt.endBlock && !evt.byteMatch) |=> cur.state == DMC_SUSPENDED) // [R08]
    else $error("continuous mode did not suspend");
  a_setup_class: assert property (@(posedge clk) disable iff (!rst_n)
      (wrByte && cur.state == DMC_DISABLED && isTsBase && cur.ptrPend == 4'h0)
      |=> opClass == $past(host.data[1:0]) && srcIsPortA == $past(host.data[2])) // [R14] [R15] [R16]
    else $error("setup base not decoded");
  a_addr_low_load: assert property (@(posedge clk) disable iff (!rst_n)
      (wrByte && cur.state == DMC_DISABLED && cur.ptrPend[0] && !isCmd && !isTsBase &&
       !isCfgBase) |=> portAStart[7:0] == $past(host.data)) // [R13] [R17]
    else $error("start low byte not loaded");
  c_enable_run: cover property (@(posedge clk) cur.state == DMC_OPERATING);
  c_suspend: cover property (@(posedge clk) cur.state == DMC_SUSPENDED);
  c_len_load: cover property (@(posedge clk) cur.ptrPend[3] ##1 !cur.ptrPend[3]);
endmodule
`default_nettype wire

/* dmc_bus_partner.sv */
// bus arbiter model that answers the engine's active-low bus request.
// assumes one clock shared with the engine and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dmc_bus_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic busReqN,
  input wire logic revoke,
  input wire logic [1:0] lag,
  output logic busAck
);
  logic [1:0] waitCnt;
  // ----------------------------------------------------------------
  // grant logic
  // ----------------------------------------------------------------
  // grant after lag+1 cycles of steady request; revoke models a lost grant
  always_ff @(posedge clk) begin
    if (!rst_n || busReqN || revoke) begin
      busAck <= 1'h0;
      waitCnt <= 2'h0;
    end else if (waitCnt != lag) begin
      waitCnt <= waitCnt + 2'h1;
    end else begin
      busAck <= 1'h1; // grant stands while the request stands
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the dma control-byte front end.
// assumes dmc_pkg, dmc_ctrl and dmc_bus_partner are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_consts.svh"
module testbench;
  import dmc_pkg::*;
  typedef struct packed {
    logic kind;
    logic [1:0] cls;
    logic src;
    logic [15:0] st;
    logic [15:0] ln;
    logic req;
  } dmc_note_s;
  logic clk, busReqN, srcIsPortA, isMaster, busAck;
  logic rst_n = 1'h0, rdyPin = 1'h0, revoke = 1'h0, probe = 1'h0;
  logic [1:0] opClass;
  logic [1:0] lag = 2'h0;
  logic [7:0] statusOut, cfgBase, d1, d2, d3, d4;
  logic [15:0] portAStart, blockLen;
  dmc_host_s host = '0;
  dmc_evt_s evtDrv = '0;
  dmc_evt_s evt;
  dmc_mode_e mode = DMC_MODE_BYTE;
  dmc_note_s q[$];
  dmc_note_s mirror = '0;
  int fails = 0, compares = 0, cycles = 0, seed = 15;
  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  dmc_ctrl dut_u (.clk(clk), .rst_n(rst_n), .host(host), .evt(evt), .mode(mode),
    .rdyPin(rdyPin), .busReqN(busReqN), .statusOut(statusOut), .opClass(opClass),
    .srcIsPortA(srcIsPortA), .portAStart(portAStart), .blockLen(blockLen),
    .cfgBase(cfgBase), .isMaster(isMaster));
  dmc_bus_partner part_u (.clk(clk), .rst_n(rst_n), .busReqN(busReqN), .revoke(revoke),
    .lag(lag), .busAck(busAck));
  // the grant comes from the partner, every other event from the bench
  always_comb begin
    evt = evtDrv;
    evt.busAckIn = busAck;
  end
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // drivers and checks
  // ----------------------------------------------------------------
  // one byte per call; back to back calls keep the strobe up
  task automatic wr(input logic [7:0] d);
    host <= '{sel: 1'h1, wr: 1'h1, rd: 1'h0, data: d};
    @(posedge clk);
  endtask
  task automatic rest(input int n);
    host <= '0;
    repeat (n) @(posedge clk);
  endtask
  // data bytes keep bit 7 high and class bits clear so none reads as a base byte
  function automatic logic [7:0] rnd();
    rnd = 8'h80 | (8'($random(seed)) & 8'h7c);
  endfunction
  task automatic post(input dmc_note_s n);
    q.push_back(n);
    probe <= 1'h1;
    @(posedge clk);
    probe <= 1'h0;
    @(posedge clk);
  endtask
  task automatic expect_regs();
    post(mirror);
  endtask
  task automatic expect_req(input logic r);
    dmc_note_s n;
    n = '0;
    n.kind = 1'h1;
    n.req = r;
    post(n);
  endtask
  task automatic cmp_regs(input dmc_note_s n);
    compares++;
    if ({opClass, srcIsPortA, portAStart, blockLen} !== {n.cls, n.src, n.st, n.ln}) begin
      fails++;
      $display("mismatch at %0t: regs %h %h %h %h", $time, opClass, srcIsPortA, portAStart,
        blockLen);
    end
  endtask
  task automatic cmp_req(input logic r);
    compares++;
    if (busReqN !== r || isMaster !== !r) begin
      fails++;
      $display("mismatch at %0t: request %b master %b", $time, busReqN, isMaster);
    end
  endtask
  // watcher takes the oldest note whenever a result is presented
  always @(posedge clk) begin : watch
    dmc_note_s n;
    if (probe === 1'h1 && q.size() > 0) begin
      n = q.pop_front();
      if (n.kind) cmp_req(n.req);
      else cmp_regs(n);
    end
  end
  task automatic close_out();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hang counts as a mismatch; the full run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    expect_regs();
    expect_req(1'h1);
    // every class with both source ports, all four pointers back to back
    for (int s = 0; s < 2; s++) begin
      for (int c = 1; c < 4; c++) begin
        d1 = rnd();
        d2 = rnd();
        d3 = rnd();
        d4 = rnd();
        wr({1'h0, 4'hf, s[0], c[1:0]});
        wr(d1);
        wr(d2);
        wr(d3);
        wr(d4);
        rest(2);
        mirror = '{kind: 1'h0, cls: c[1:0], src: s[0], st: {d2, d1}, ln: {d4, d3}, req: 1'h0};
        expect_regs();
      end
    end
    // sparse pointers skip unset registers but keep the order
    d1 = rnd();
    d2 = rnd();
    wr(8'h52);
    wr(d1);
    wr(d2);
    rest(2);
    mirror.cls = 2'h2;
    mirror.src = 1'h0;
    mirror.st[15:8] = d1;
    mirror.ln[15:8] = d2;
    expect_regs();
    // a new base byte ends the pending loads; class 00 is another group
    wr(8'h79);
    wr(d3);
    wr(8'h05);
    wr(d4);
    wr(8'h04);
    rest(2);
    mirror.cls = 2'h1;
    mirror.src = 1'h1;
    mirror.st[7:0] = d3;
    expect_regs();
    evtDrv.selfXfer <= 1'h1;
    wr(8'h02);
    evtDrv.selfXfer <= 1'h0;
    rest(2);
    expect_regs();
    // enable with ready low, then disable before ready rises
    wr(`DMC_CMD_ENABLE);
    rest(4);
    expect_req(1'h1);
    wr(`DMC_CMD_DISABLE);
    rest(1);
    rdyPin <= 1'h1;
    rest(4);
    expect_req(1'h1);
    wr(`DMC_CMD_ENABLE);
    rest(4);
    expect_req(1'h0);
    wr(8'h7d);
    rest(8);
    expect_regs();
    expect_req(1'h0);
    revoke <= 1'h1;
    rest(3);
    expect_req(1'h1);
    revoke <= 1'h0;
    // forced ready with a slow partner, ended by block end
    lag <= 2'h3;
    rdyPin <= 1'h0;
    rest(3);
    wr(`DMC_CMD_FORCE_RDY);
    wr(`DMC_CMD_ENABLE);
    rest(6);
    expect_req(1'h0);
    evtDrv.endBlock <= 1'h1;
    @(posedge clk);
    evtDrv.endBlock <= 1'h0;
    rest(3);
    expect_req(1'h1);
    // continuous mode with ready low holds the bus, match ends it
    mode <= DMC_MODE_CONT;
    wr(`DMC_CMD_ENABLE);
    rest(4);
    expect_req(1'h0);
    evtDrv.byteMatch <= 1'h1;
    @(posedge clk);
    evtDrv.byteMatch <= 1'h0;
    rest(3);
    expect_req(1'h1);
    // auto restart keeps the bus at block end; a reset drops everything
    mode <= DMC_MODE_BYTE;
    rdyPin <= 1'h1;
    evtDrv.autoRestart <= 1'h1;
    rest(3);
    wr(`DMC_CMD_ENABLE);
    rest(6);
    evtDrv.endBlock <= 1'h1;
    @(posedge clk);
    evtDrv.endBlock <= 1'h0;
    rest(3);
    expect_req(1'h0);
    rst_n <= 1'h0;
    rest(2);
    rst_n <= 1'h1;
    mirror = '0;
    expect_req(1'h1);
    expect_regs();
    close_out();
  end
endmodule
`default_nettype wire
